// ===== core/frpd_pkg.sv
// Constants shared by the reset / power-down command decoder.
// Assumes a 25 MHz system clock sampling a slower host serial clock.
package frpd_pkg;

    // ==============================================================
    // Instruction codes
    localparam logic [7:0] RESET_ARM_CMD = 8'h66;
    localparam logic [7:0] SOFT_RESET_CMD = 8'h99;
    localparam logic [7:0] CONT_READ_EXIT_CMD = 8'hff;
    localparam logic [7:0] POWER_DOWN_ENTRY_CMD = 8'hb9;
    localparam logic [7:0] POWER_DOWN_RELEASE_ID_CMD = 8'hab;
    localparam logic [7:0] PARAM_SPACE_READ_CMD = 8'h5a;

    // ==============================================================
    // Frame layout, in serial clocks
    localparam logic [6:0] SINGLE_INST_CLKS = 7'h08;
    localparam logic [6:0] QUAD_INST_CLKS = 7'h02;
    localparam logic [6:0] SINGLE_ADDR_CLKS = 7'h18;
    localparam logic [6:0] QUAD_ADDR_CLKS = 7'h06;
    localparam logic [6:0] PARAM_DUMMY_CLKS = 7'h08;
    localparam logic [6:0] CLK_CNT_MAX = 7'h7f;
    localparam logic [2:0] SINGLE_BYTE_LAST = 3'h7;
    localparam logic [2:0] QUAD_BYTE_LAST = 3'h1;

    // ==============================================================
    // Parameter space map
    localparam logic [23:0] PARAM_HDR_BASE = 24'h000000;
    localparam logic [23:0] PARAM_DATA_BASE = 24'h000300;
    localparam int PARAM_HDR_LEN = 6;
    localparam logic [7:0] PARAM_UNDEFINED = 8'hff;
    localparam logic [7:0] PARAM_BLANK = 8'h00;

    // ==============================================================
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int POWER_DOWN_ENTRY_TIME_NS = 3000;
    localparam int RELEASE_RECOVERY_TIME_NS = 3000;
    localparam int SOFT_RESET_RECOVERY_TIME_NS = 30000;
    // Longest times: round down, never below one cycle
    localparam int DP_CYC = (POWER_DOWN_ENTRY_TIME_NS / CLK_PERIOD_NS > 0)
        ? POWER_DOWN_ENTRY_TIME_NS / CLK_PERIOD_NS : 1;
    localparam int RES_CYC = (RELEASE_RECOVERY_TIME_NS / CLK_PERIOD_NS > 0)
        ? RELEASE_RECOVERY_TIME_NS / CLK_PERIOD_NS : 1;
    localparam int RPH_CYC =
        (SOFT_RESET_RECOVERY_TIME_NS / CLK_PERIOD_NS > 0)
        ? SOFT_RESET_RECOVERY_TIME_NS / CLK_PERIOD_NS : 1;
    localparam logic [9:0] DP_LOAD = 10'(DP_CYC - 1);
    localparam logic [9:0] RES_LOAD = 10'(RES_CYC - 1);
    localparam logic [9:0] RPH_LOAD = 10'(RPH_CYC - 1);

    // ==============================================================
    // Reset values of the protection bits
    localparam logic PROTECT_RESET = 1'b0;
    localparam logic LOCK_RESET = 1'b1;

    typedef enum logic [4:0] {
        ST_NORMAL = 5'b00001,
        ST_PD_ENTER = 5'b00010,
        ST_PD = 5'b00100,
        ST_PD_RELEASE = 5'b01000,
        ST_SOFT_RST = 5'b10000
    } frpd_state_type;

endpackage

// ===== core/frpd_sync.sv
// Two-flop synchroniser for the serial pins.
// Assumes inputs are asynchronous to i_clk; resets to all ones (idle).
`timescale 1ns/100ps
`default_nettype none

module frpd_sync #(
    parameter int WIDTH = 6
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta;

    // ==============================================================
    // Checks
    if (WIDTH < 1) begin : g_bad_width
        $error("frpd_sync: WIDTH must be at least 1");
    end

    // ==============================================================
    // One stage pair per bit
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                meta[b] <= 1'b1;
                o_sync[b] <= 1'b1;
            end else begin
                meta[b] <= i_async[b];
                o_sync[b] <= meta[b];
            end
        end
    end

endmodule // frpd_sync

`default_nettype wire

// ===== core/frpd_cmd.sv
// Reset, continuous-read exit, power-down and parameter-space decoder.
// Assumes the host serial clock is slower than a quarter of i_clk.
//
// What this block does
// (R01) Software reset needs the arm command immediately before execute.
// (R02) Any other completed command clears the armed condition.
// (R03) Execute directly after arm starts the software reset.
// (R04) Continuous-read exit returns the device to standby.
// (R05) Host sends ones on IO0 for eight clocks; IO1-IO3 ignored.
// (R06) Host should send exit after system reset or before reset.
// (R07) Power-down runs only if chip select rises after bit eight.
// (R08) Power-down state entered within the entry time.
// (R09) Powered down, only the release/ID command is recognised.
// (R10) Hardware reset while powered down restores normal operation.
// (R11) Device always powers up in normal standby.
// (R12) Quad-instruction mode takes power-down on four IO lines.
// (R13) After release, operation resumes only after the release time.
// (R14) ID shifts out MSB first on falling edges after 3 dummies.
// (R15) Clocking past the ID repeats the ID; chip select ends.
// (R16) Release/ID while array busy is ignored, cycle unaffected.
// (R17) Quad mode: ID instruction and data on four IO lines.
// (R18) Parameter read uses a separate identification address space.
// (R19) Header at zero, parameter data at 0300h, rest undefined.
// (R20) Parameter space is read-only to the host.
// (R21) Soft reset reloads volatiles but keeps protect and lock bits.
// (R22) Soft reset begins at chip select rise, lasts recovery time.
// (R23) One armed flag: set by arm, cleared by other commands.
// (R24) Only complete eight-bit instructions decode; partials dropped.
`timescale 1ns/100ps
`default_nettype none

module frpd_cmd
    import frpd_pkg::*;
#(
    parameter logic [7:0] DEVICE_ID = 8'h3c, // Arbitrary value
    parameter int PARAM_DATA_LEN = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic [3:0] i_io,
    input wire logic i_quad_instruction_mode,
    input wire logic i_cont_read,
    input wire logic i_busy,
    input wire logic i_set_status_protect,
    input wire logic i_clear_protection_lock,
    output logic [3:0] o_io,
    output logic [3:0] o_io_oe,
    output logic o_ready,
    output logic o_power_down,
    output logic o_soft_reset_busy,
    output logic o_reload_volatile,
    output logic o_cont_read_exit,
    output logic o_volatile_status_protect_bit,
    output logic o_protection_lock_bit
);

    // ==============================================================
    // Checks
    if (PARAM_DATA_LEN < 1 || PARAM_DATA_LEN > 256) begin : g_bad_len
        $error("frpd_cmd: PARAM_DATA_LEN must be 1..256");
    end

    localparam logic [7:0] HDR_ROM [PARAM_HDR_LEN] =
        '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01};

    // ==============================================================
    // Helpers
    function automatic logic [6:0] pick(input logic quad,
        input logic [6:0] single_v, input logic [6:0] quad_v);
        pick = quad ? quad_v : single_v;
    endfunction

    // No write path exists into this table [R20]
    function automatic logic [7:0] param_byte(input logic [23:0] a);
        logic [23:0] off;
        off = a - PARAM_DATA_BASE;
        if (a - PARAM_HDR_BASE < 24'(PARAM_HDR_LEN)) begin
            param_byte = HDR_ROM[a[2:0]]; // [R19]
        end else if (a >= PARAM_DATA_BASE &&
            off < 24'(PARAM_DATA_LEN)) begin
            param_byte = PARAM_BLANK; // [R18]
        end else begin
            param_byte = PARAM_UNDEFINED;
        end
    endfunction

    // ==============================================================
    // Pin synchronisation and edges
    logic [5:0] pin_s;
    logic cs_n_s;
    logic sck_s;
    logic [3:0] io_s;
    logic sck_d;
    logic cs_d;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;

    frpd_sync #(.WIDTH(6)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async({i_cs_n, i_sck, i_io}),
        .o_sync(pin_s)
    );

    assign cs_n_s = pin_s[5];
    assign sck_s = pin_s[4];
    assign io_s = pin_s[3:0];

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sck_d <= 1'b1;
            cs_d <= 1'b1;
        end else begin
            sck_d <= sck_s;
            cs_d <= cs_n_s;
        end
    end

    assign sck_rise = sck_s & ~sck_d & ~cs_n_s;
    assign sck_fall = ~sck_s & sck_d & ~cs_n_s;
    assign cs_rise = cs_n_s & ~cs_d;

    // ==============================================================
    // Frame decode
    frpd_state_type st;
    frpd_state_type next_st;
    logic [9:0] timer;
    logic [9:0] next_timer;
    logic [6:0] clk_cnt;
    logic [7:0] instr;
    logic [23:0] addr;
    logic [7:0] out_sr;
    logic [2:0] out_cnt;
    logic armed;
    logic quad;
    logic [6:0] inst_clks;
    logic [6:0] addr_end;
    logic cmd_ok;
    logic exact;
    logic is_id;
    logic is_param;
    logic sending;
    logic [7:0] cur_byte;

    // Exit frames are always serial on IO0 [R05]
    assign quad = i_quad_instruction_mode & ~i_cont_read;
    assign inst_clks = pick(quad, SINGLE_INST_CLKS, QUAD_INST_CLKS);
    assign addr_end = inst_clks +
        pick(quad, SINGLE_ADDR_CLKS, QUAD_ADDR_CLKS);
    assign cmd_ok = clk_cnt >= inst_clks; // [R24]
    assign exact = clk_cnt == inst_clks; // [R07]

    // ID read refused while the array is busy [R16]
    assign is_id = cmd_ok && instr == POWER_DOWN_RELEASE_ID_CMD &&
        !i_busy && (st == ST_NORMAL || st == ST_PD);
    assign is_param = cmd_ok && instr == PARAM_SPACE_READ_CMD &&
        !i_busy && st == ST_NORMAL;
    // ID after 3 dummy bytes, parameters after address and dummies
    assign sending = (is_id && clk_cnt >= addr_end) ||
        (is_param && clk_cnt >= addr_end + PARAM_DUMMY_CLKS); // [R14]

    always_ff @(posedge i_clk) begin
        if (i_rst || cs_n_s) begin
            clk_cnt <= 7'h00;
            instr <= 8'h00;
            addr <= 24'h000000;
        end else if (sck_rise) begin
            if (clk_cnt != CLK_CNT_MAX) begin
                clk_cnt <= clk_cnt + 7'h01;
            end
            if (clk_cnt < inst_clks) begin
                instr <= quad ? {instr[3:0], io_s}
                    : {instr[6:0], io_s[0]}; // [R12] [R17]
            end else if (clk_cnt < addr_end) begin
                addr <= quad ? {addr[19:0], io_s}
                    : {addr[22:0], io_s[0]};
            end
        end else if (sck_fall && sending && is_param &&
            out_cnt == 3'h0) begin
            addr <= addr + 24'h000001;
        end
    end

    // ==============================================================
    // Data out on falling edges, MSB first
    always_comb begin
        if (out_cnt != 3'h0) begin
            cur_byte = out_sr;
        end else if (is_id) begin
            cur_byte = DEVICE_ID; // Repeats past the ID [R15]
        end else begin
            cur_byte = param_byte(addr);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || cs_n_s) begin
            o_io <= 4'h0;
            o_io_oe <= 4'h0;
            out_sr <= 8'h00;
            out_cnt <= 3'h0;
        end else if (sck_fall && sending) begin
            if (quad) begin
                o_io <= cur_byte[7:4]; // [R17]
                o_io_oe <= 4'hf;
                out_sr <= {cur_byte[3:0], 4'h0};
                out_cnt <= (out_cnt == 3'h0) ? QUAD_BYTE_LAST
                    : out_cnt - 3'h1;
            end else begin
                o_io <= {2'h0, cur_byte[7], 1'b0}; // [R14]
                o_io_oe <= 4'h2;
                out_sr <= {cur_byte[6:0], 1'b0};
                out_cnt <= (out_cnt == 3'h0) ? SINGLE_BYTE_LAST
                    : out_cnt - 3'h1;
            end
        end
    end

    // ==============================================================
    // Reset arming
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            armed <= 1'b0;
        end else if (cs_rise && cmd_ok && st == ST_NORMAL) begin
            armed <= exact && instr == RESET_ARM_CMD; // [R02] [R23]
        end
    end

    // ==============================================================
    // Operating state
    always_comb begin
        next_st = st;
        next_timer = (timer != 10'h000) ? timer - 10'h001 : timer;
        case (st)
            ST_NORMAL: begin
                if (cs_rise && exact &&
                    instr == POWER_DOWN_ENTRY_CMD) begin
                    next_st = ST_PD_ENTER; // [R07]
                    next_timer = DP_LOAD;
                end else if (cs_rise && exact && armed &&
                    instr == SOFT_RESET_CMD) begin
                    next_st = ST_SOFT_RST; // [R01] [R03] [R22]
                    next_timer = RPH_LOAD;
                end
            end
            ST_PD_ENTER: begin
                if (timer == 10'h000) begin
                    next_st = ST_PD; // [R08]
                end
            end
            ST_PD: begin
                // Everything but release is dropped here [R09]
                if (cs_rise && cmd_ok && !i_busy &&
                    instr == POWER_DOWN_RELEASE_ID_CMD) begin
                    next_st = ST_PD_RELEASE;
                    next_timer = RES_LOAD;
                end
            end
            ST_PD_RELEASE: begin
                if (timer == 10'h000) begin
                    next_st = ST_NORMAL; // [R13]
                end
            end
            ST_SOFT_RST: begin
                if (timer == 10'h000) begin
                    next_st = ST_NORMAL; // [R22]
                end
            end
            default: begin
                next_st = ST_NORMAL;
                next_timer = 10'h000;
            end
        endcase
    end

    // Power-on or hardware reset always lands in standby [R10] [R11]
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= ST_NORMAL;
            timer <= 10'h000;
        end else begin
            st <= next_st;
            timer <= next_timer;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ready <= 1'b1;
            o_power_down <= 1'b0;
            o_soft_reset_busy <= 1'b0;
            o_reload_volatile <= 1'b0;
        end else begin
            o_ready <= next_st == ST_NORMAL;
            o_power_down <= next_st == ST_PD;
            o_soft_reset_busy <= next_st == ST_SOFT_RST;
            o_reload_volatile <= st == ST_NORMAL &&
                next_st == ST_SOFT_RST; // [R21]
        end
    end

    // ==============================================================
    // Continuous-read exit
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_cont_read_exit <= 1'b0;
        end else begin
            o_cont_read_exit <= cs_rise && exact && i_cont_read &&
                st == ST_NORMAL && instr == CONT_READ_EXIT_CMD; // [R04]
        end
    end

    // ==============================================================
    // Protection bits survive soft reset; only i_rst restores them
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_volatile_status_protect_bit <= PROTECT_RESET;
            o_protection_lock_bit <= LOCK_RESET;
        end else begin
            if (i_set_status_protect) begin
                o_volatile_status_protect_bit <= 1'b1; // [R21]
            end
            if (i_clear_protection_lock) begin
                o_protection_lock_bit <= 1'b0; // [R21]
            end
        end
    end

    // ==============================================================
    // Assertions
    localparam int LP_DP_MAX = DP_CYC + 1;
    localparam int LP_RES_MAX = RES_CYC + 1;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_pd_cmd;
        st == ST_NORMAL && cs_rise && exact &&
            instr == POWER_DOWN_ENTRY_CMD;
    endsequence

    sequence s_release_cmd;
        st == ST_PD && cs_rise && cmd_ok && !i_busy &&
            instr == POWER_DOWN_RELEASE_ID_CMD;
    endsequence

    property p_rst_needs_arm;
        $rose(o_soft_reset_busy) |-> $past(armed, 2);
    endproperty
    a_rst_needs_arm: assert property (p_rst_needs_arm) // [R01] [R03]
        else $error("soft reset started without arm");

    property p_disarm;
        st == ST_NORMAL && cs_rise && cmd_ok &&
            instr != RESET_ARM_CMD |=> !armed;
    endproperty
    a_disarm: assert property (p_disarm) // [R02]
        else $error("arm survived another command");

    property p_pd_exact;
        $rose(st == ST_PD_ENTER) |-> $past(exact) && $past(cs_rise);
    endproperty
    a_pd_exact: assert property (p_pd_exact) // [R07]
        else $error("power-down without exact eight bits");

    property p_pd_entry;
        s_pd_cmd |-> ##[1:LP_DP_MAX] o_power_down;
    endproperty
    a_pd_entry: assert property (p_pd_entry) // [R08]
        else $error("power-down not entered in time");

    property p_pd_ignore;
        st == ST_PD && cs_rise &&
            instr != POWER_DOWN_RELEASE_ID_CMD |=> st == ST_PD;
    endproperty
    a_pd_ignore: assert property (p_pd_ignore) // [R09]
        else $error("command acted on while powered down");

    property p_release;
        s_release_cmd |=> !o_ready [*8] ##[1:LP_RES_MAX] o_ready;
    endproperty
    a_release: assert property (p_release) // [R13]
        else $error("release recovery wrong");

    property p_power_up;
        $past(i_rst) |-> o_ready && !o_power_down;
    endproperty
    a_power_up: assert property (p_power_up) // [R11] [R10]
        else $error("not in standby after reset");

    // Watches the state, not the gate term, so a broken gate shows
    property p_busy_ignore;
        st == ST_PD && cs_rise && i_busy |=> st == ST_PD;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) // [R16]
        else $error("ID read accepted while busy");

    property p_id_first;
        !quad && $rose(o_io_oe[1]) && is_id |-> o_io[1] == DEVICE_ID[7];
    endproperty
    a_id_first: assert property (p_id_first) // [R14]
        else $error("ID MSB not first");

    property p_exit;
        st == ST_NORMAL && cs_rise && exact && i_cont_read &&
            instr == CONT_READ_EXIT_CMD |=> o_cont_read_exit;
    endproperty
    a_exit: assert property (p_exit) // [R04]
        else $error("continuous-read exit missed");

    property p_keep_bits;
        o_soft_reset_busy && !i_set_status_protect &&
            !i_clear_protection_lock |=>
            $stable(o_volatile_status_protect_bit) &&
            $stable(o_protection_lock_bit);
    endproperty
    a_keep_bits: assert property (p_keep_bits) // [R21]
        else $error("soft reset changed protection bits");

endmodule // frpd_cmd

`default_nettype wire

// ===== verif/frpd_host.sv
// Host side model: drives chip select, serial clock and IO lines.
// Assumes the bench calls its tasks; IO inputs carry the resolved wires.
`timescale 1ns/100ps
`default_nettype none

module frpd_host (
    input wire logic i_clk,
    input wire logic i_quad,
    input wire logic [3:0] i_io,
    output logic o_cs_n,
    output logic o_sck,
    output logic [3:0] o_io
);
    // ==========================================================
    // Timing
    // Six cycles a half period keeps the device output settled
    localparam int HALF = 6;

    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_io = 4'hf;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // ==========================================================
    // Frame tasks
    task automatic start();
        tick(HALF);
        o_cs_n = 1'b0;
        tick(HALF);
    endtask

    // MSB first; quad moves a nibble per clock, high nibble first
    task automatic shift(input logic [31:0] v, input int nbits,
                         output logic [31:0] rd);
        int nclk;
        nclk = i_quad ? nbits / 4 : nbits;
        rd = 32'h0;
        for (int i = nclk - 1; i >= 0; i--) begin
            if (i_quad) begin
                o_io = v[4*i +: 4];
            end else begin
                o_io[0] = v[i];
                o_io[3:1] = o_io[3:1] + 3'h1; // Noise on unused lines
            end
            tick(HALF);
            o_sck = 1'b1;
            rd = i_quad ? {rd[27:0], i_io} : {rd[30:0], i_io[1]};
            tick(HALF);
            o_sck = 1'b0;
        end
    endtask

    // Chip select rises one half period after the last falling clock edge
    task automatic stop();
        tick(HALF);
        o_cs_n = 1'b1;
        o_io = ~o_io;
        tick(1);
    endtask
endmodule // frpd_host

`default_nettype wire

// ===== verif/frpd_cmd_tb.sv
// Self-checking bench for the reset / power-down command decoder.
// Assumes frpd_pkg and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module frpd_cmd_tb;
    import frpd_pkg::*;
    localparam logic [7:0] ID = 8'h5e; // Arbitrary value
    logic clk, rst, quad, cont_read, busy, set_prot, clr_lock;
    logic cs_n, sck, ready, pd, srst_busy, reload, exit_p, prot, lock;
    logic [3:0] host_io, dev_io, dev_oe, line;
    logic [31:0] rd;
    int fail_count = 0;
    int samples_checked = 0;
    // Wire level: an enabled device output wins over the host
    assign line = (dev_oe & dev_io) | (~dev_oe & host_io);

    frpd_cmd #(.DEVICE_ID(ID), .PARAM_DATA_LEN(16)) i_frpd_cmd (
        .i_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_sck(sck), .i_io(line),
        .i_quad_instruction_mode(quad), .i_cont_read(cont_read),
        .i_busy(busy), .i_set_status_protect(set_prot),
        .i_clear_protection_lock(clr_lock), .o_io(dev_io), .o_io_oe(dev_oe),
        .o_ready(ready), .o_power_down(pd), .o_soft_reset_busy(srst_busy),
        .o_reload_volatile(reload), .o_cont_read_exit(exit_p),
        .o_volatile_status_protect_bit(prot), .o_protection_lock_bit(lock));
    frpd_host i_frpd_host (.i_clk(clk), .i_quad(quad), .i_io(line),
        .o_cs_n(cs_n), .o_sck(sck), .o_io(host_io));

    // ==========================================================
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Flags: 0 reload, 1 ready, 2 power down, 3 exit
    task automatic wait_for(input int sel, input logic lvl, input int lim,
                            output int n);
        logic [3:0] f;
        for (n = 0; n <= lim; n++) begin
            f = {exit_p, pd, ready, reload};
            if (f[sel] === lvl) return;
            tick(1);
        end
        check("wait_bound", 32'h1, 32'h0);
        complete_run();
    endtask
    task automatic quiet(input int sel, input logic lvl, input int n);
        logic [3:0] f;
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            f = {exit_p, pd, ready, reload};
            if (f[sel] !== lvl) bad = 1'b1;
            tick(1);
        end
        check("flag_steady", {31'h0, bad}, 32'h0);
    endtask
    task automatic cmd(input logic [31:0] v, input int nb);
        i_frpd_host.start();
        i_frpd_host.shift(v, nb, rd);
        i_frpd_host.stop();
    endtask
    task automatic hw_reset();
        rst = 1'b1;
        tick(16);
        rst = 1'b0;
        check("rst_state", {ready, pd, srst_busy, prot, lock}, 5'b10001);
        tick(4);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_exit();
        int n;
        cont_read = 1'b1;
        cmd(32'hff, 8); // Exit first after reset
        wait_for(3, 1'b1, 20, n);
        tick(1);
        check("exit_pulse", exit_p, 1'b0);
        cont_read = 1'b0;
    endtask
    task automatic t_soft();
        int n;
        set_prot = 1'b1;
        clr_lock = 1'b1;
        tick(1);
        set_prot = 1'b0;
        clr_lock = 1'b0;
        cmd(RESET_ARM_CMD, 8);
        cmd(32'h05, 8);
        cmd(SOFT_RESET_CMD, 8);
        quiet(0, 1'b0, 60);
        cmd(RESET_ARM_CMD, 8);
        cmd(SOFT_RESET_CMD, 8);
        wait_for(0, 1'b1, 20, n);
        check("busy_ready", {srst_busy, ready}, 2'b10);
        wait_for(1, 1'b1, RPH_CYC + 20, n);
        check("rst_time", n >= RPH_CYC - 2 && n <= RPH_CYC + 2, 1'b1);
        check("kept_bits", {prot, lock}, 2'b10);
        hw_reset();
    endtask
    task automatic t_power_down();
        int n;
        cmd(32'h5c, 7); // Seven bits only
        quiet(2, 1'b0, 100);
        cmd(32'h172, 9); // Chip select late by one bit
        quiet(2, 1'b0, 100);
        cmd(POWER_DOWN_ENTRY_CMD, 8);
        wait_for(2, 1'b1, DP_CYC + 20, n);
        check("pd_time", n >= DP_CYC && n <= DP_CYC + 8, 1'b1);
        cmd(32'h05, 8);
        cmd(RESET_ARM_CMD, 8);
        cmd(SOFT_RESET_CMD, 8);
        quiet(2, 1'b1, 40);
        busy = 1'b1;
        cmd(POWER_DOWN_RELEASE_ID_CMD, 8);
        quiet(2, 1'b1, 40);
        busy = 1'b0;
        cmd(POWER_DOWN_RELEASE_ID_CMD, 8);
        wait_for(2, 1'b0, 20, n);
        check("ready_hold", ready, 1'b0);
        wait_for(1, 1'b1, RES_CYC + 20, n);
        check("res_time", n >= RES_CYC - 8 && n <= RES_CYC + 2, 1'b1);
        cmd(POWER_DOWN_ENTRY_CMD, 8);
        wait_for(2, 1'b1, DP_CYC + 20, n);
        hw_reset();
        check("hw_exit", pd, 1'b0);
    endtask
    task automatic t_id();
        int n;
        i_frpd_host.start();
        i_frpd_host.shift(POWER_DOWN_RELEASE_ID_CMD, 8, rd);
        i_frpd_host.shift(32'h0, 24, rd);
        i_frpd_host.shift(32'h0, 16, rd);
        i_frpd_host.stop();
        check("id_single", rd[15:0], {ID, ID});
        tick(6);
        check("oe_off", dev_oe, 4'h0);
        tick(RES_CYC + 10);
        quad = 1'b1;
        cmd(POWER_DOWN_ENTRY_CMD, 8);
        wait_for(2, 1'b1, DP_CYC + 20, n);
        i_frpd_host.start();
        i_frpd_host.shift(POWER_DOWN_RELEASE_ID_CMD, 8, rd);
        i_frpd_host.shift(32'h0, 24, rd);
        i_frpd_host.shift(32'h0, 8, rd);
        i_frpd_host.stop();
        check("id_quad", rd[7:0], ID);
        wait_for(1, 1'b1, RES_CYC + 20, n);
        check("quad_release", pd, 1'b0);
        quad = 1'b0;
    endtask
    task automatic t_param();
        logic [23:0] addr [4] = '{24'h0, 24'h4, 24'h300, 24'h310};
        logic [31:0] exp [4] = '{32'h53464450, 32'h0601, 32'h0, 32'hff};
        int nb [4] = '{32, 16, 8, 8};
        for (int k = 0; k < 4; k++) begin
            i_frpd_host.start();
            i_frpd_host.shift(PARAM_SPACE_READ_CMD, 8, rd);
            i_frpd_host.shift({8'h0, addr[k]}, 24, rd);
            i_frpd_host.shift(32'h0, 8, rd);
            i_frpd_host.shift(32'h0, nb[k], rd);
            i_frpd_host.stop();
            check("param_data", rd, exp[k]);
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        quad = 1'b0;
        cont_read = 1'b0;
        busy = 1'b0;
        set_prot = 1'b0;
        clr_lock = 1'b0;
        tick(1);
        hw_reset();
        t_exit();
        t_soft();
        t_power_down();
        t_id();
        t_param();
        complete_run();
    end
endmodule // frpd_cmd_tb

`default_nettype wire
